// ---- core/fsr_status_regs.sv ----
// Status and protection register bank of a serial flash.
// Instructions arrive on the link clock with a toggle strobe; the busy
// engine and the registers live on the system clock.
`timescale 1ns/1ns

// Contract
// - Busy is one during program, erase, writes
// - While busy, ignore all but suspend
// - Busy clears when the operation ends
// - Write enable sets the latch
// - Latch clears at power-up and writes
// - Size code bits S4..S2, default zero
// - S5 selects low end protection
// - S6 selects small sector granularity
// - Lock pair 00 allows writes freely
// - Lock 01 with pin low rejects writes
// - Lock 01 pin high needs latch
// - Lock 10 blocks until power cycle
// - Lock 11 blocks writes forever
// - Quad enable repurposes protect and hold; here the protect pin still gates lock 01 writes
// - Invert bit flips protected region
// - Paused flag set by suspend, cleared resume
// - Ignore program into protected area
module fsr_status_regs
    import fsr_pkg::*;
(
    input  wire logic             clock,         // System clock
    input  wire logic             rst_n,         // Power-up reset
    input  wire logic             link_clock,    // Host serial clock
    input  wire logic             link_rst_n,    // Link-side reset
    input  wire fsr_pkg::fsr_req_t link_req,     // Decoded instruction
    input  wire logic             link_req_valid,// One link cycle pulse
    input  wire logic             protect_pin,   // Write-protect pin level
    input  wire logic             op_done,       // Array engine finished
    input  wire logic [15:0]      nv_image,      // Stored non-volatile bits
    output logic      [15:0]      status_word,   // Readback of both bytes
    output logic                  nv_store,      // Pulse: store new image
    output logic      [15:0]      nv_store_data, // Image to store
    output logic                  op_start,      // Pulse: start array op
    output logic                  quad_mode      // Pins act as IO2/IO3
);
    import fsr_pkg::*;

    // Synchronised reset copy for the system domain
    logic rst_s1_reg;
    logic rst_s2_reg;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end
    wire logic rst_sys_n = rst_s2_reg;

    // Link side: capture request and flip a toggle; the word is held stable
    // until the next request, which the host spaces far apart.
    fsr_req_t link_hold_reg;   // Request held for the crossing
    logic     link_tog_reg;    // Flips once per request
    always_ff @(posedge link_clock or negedge link_rst_n) begin
        if (!link_rst_n) begin
            link_hold_reg <= '0;
            link_tog_reg  <= 1'b0;
        end else if (link_req_valid) begin
            link_hold_reg <= link_req;
            link_tog_reg  <= ~link_tog_reg;
        end
    end

    // Toggle synchroniser and edge detect on the second stage only
    logic tog_s1_reg;
    logic tog_s2_reg;
    logic tog_s3_reg;
    always_ff @(posedge clock or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            tog_s1_reg <= 1'b0;
            tog_s2_reg <= 1'b0;
            tog_s3_reg <= 1'b0;
        end else begin
            tog_s1_reg <= link_tog_reg;
            tog_s2_reg <= tog_s1_reg;
            tog_s3_reg <= tog_s2_reg;
        end
    end
    wire logic req_evt = tog_s2_reg ^ tog_s3_reg;

    // Request word is sampled only once the toggle has settled
    fsr_req_t req_reg;
    always_ff @(posedge clock or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            req_reg <= '0;
        end else if (req_evt) begin
            req_reg <= link_hold_reg;
        end
    end
    logic req_go_reg;
    always_ff @(posedge clock or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            req_go_reg <= 1'b0;
        end else begin
            req_go_reg <= req_evt;
        end
    end

    // Pin synchroniser for the write-protect level
    logic pin_s1_reg;
    logic pin_s2_reg;
    always_ff @(posedge clock or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            pin_s1_reg <= 1'b0;
            pin_s2_reg <= 1'b0;
        end else begin
            pin_s1_reg <= protect_pin;
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // Non-volatile image loaded once after reset release
    logic [15:0] nv_reg;       // Live non-volatile bits
    logic        loaded_reg;   // Image has been taken
    logic        wel_reg;      // Write enable latch
    logic        busy_reg;     // Operation in progress
    logic        paused_reg;   // Suspend flag
    fsr_state_t  state_reg;    // Engine state
    logic [15:0] count_reg;    // Register write timer
    logic        reg_write_reg;// Current work is a status write
    logic [15:0] pend_reg;     // Status value being written
    logic        op_done_int;  // Current work has finished

    // Lock pair decode and write permission
    wire logic [1:0] lock_pair = {nv_reg[BIT_LOCK_B], nv_reg[BIT_LOCK_A]};
    logic wr_allowed;
    always_comb begin
        unique case (lock_pair)
            2'b00:   wr_allowed = wel_reg;
            2'b01:   wr_allowed = wel_reg & pin_s2_reg;
            2'b10:   wr_allowed = 1'b0;
            2'b11:   wr_allowed = 1'b0;
            default: wr_allowed = 1'b0;
        endcase
    end

    // Only suspend passes while busy; reads never reach this path
    wire logic accept = req_go_reg &&
        (!busy_reg || req_reg.cmd == CMD_SUSPEND);
    wire logic do_wrstat = accept && req_reg.cmd == CMD_WRSTAT && wr_allowed;
    wire logic do_array  = accept && wel_reg &&
        (req_reg.cmd == CMD_PROG || req_reg.cmd == CMD_ERASE) &&
        !req_reg.hits_protected;

    // Non-volatile bits: load, then change only by a permitted write
    always_ff @(posedge clock or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            nv_reg     <= NV_FACTORY;
            loaded_reg <= 1'b0;
        end else if (!loaded_reg) begin
            loaded_reg <= 1'b1;
            nv_reg     <= nv_image & WRITE_MASK | nv_image & 16'h0180;
            // Power-supply lock reverts on each power-up
            if (nv_image[BIT_LOCK_B] && !nv_image[BIT_LOCK_A]) begin
                nv_reg[BIT_LOCK_B] <= 1'b0;
            end
        end else if (state_reg == ST_WORK && reg_write_reg && op_done_int) begin
            nv_reg <= pend_reg;
        end
    end

    // Write enable latch; set and clear come from one instruction, so never meet in a cycle
    always_ff @(posedge clock or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            wel_reg <= 1'b0;
        end else if (accept) begin
            unique case (req_reg.cmd)
                CMD_WREN:   wel_reg <= 1'b1;
                CMD_WRDIS, CMD_WRSTAT, CMD_PROG, CMD_ERASE:
                            wel_reg <= 1'b0;
                default:    wel_reg <= wel_reg;
            endcase
        end
    end

    // Internal completion: timer for register writes, pin for array ops
    always_comb begin
        op_done_int = reg_write_reg ? (count_reg == 16'h0000) : op_done;
    end

    // Engine: idle, working (busy), paused by suspend
    always_ff @(posedge clock or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            state_reg     <= ST_IDLE;
            busy_reg      <= 1'b0;
            paused_reg    <= 1'b0;
            count_reg     <= 16'h0000;
            reg_write_reg <= 1'b0;
            pend_reg      <= 16'h0000;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (do_wrstat) begin
                        state_reg     <= ST_WORK;
                        busy_reg      <= 1'b1;
                        reg_write_reg <= 1'b1;
                        count_reg     <= WRITE_COUNT;
                        pend_reg      <= (req_reg.data & WRITE_MASK) |
                            (req_reg.data & 16'h0180);
                    end else if (do_array) begin
                        state_reg     <= ST_WORK;
                        busy_reg      <= 1'b1;
                        reg_write_reg <= 1'b0;
                    end
                end
                ST_WORK: begin
                    if (count_reg != 16'h0000) begin
                        count_reg <= count_reg - 16'h0001;
                    end
                    if (accept && req_reg.cmd == CMD_SUSPEND &&
                        !reg_write_reg) begin
                        state_reg  <= ST_PAUSED;
                        busy_reg   <= 1'b0;
                        paused_reg <= 1'b1;
                    end else if (op_done_int) begin
                        state_reg     <= ST_IDLE;
                        busy_reg      <= 1'b0;
                        reg_write_reg <= 1'b0;
                    end
                end
                ST_PAUSED: begin
                    if (accept && req_reg.cmd == CMD_RESUME) begin
                        state_reg  <= ST_WORK;
                        busy_reg   <= 1'b1;
                        paused_reg <= 1'b0;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Registered outputs
    always_ff @(posedge clock or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            status_word   <= 16'h0000;
            nv_store      <= 1'b0;
            nv_store_data <= 16'h0000;
            op_start      <= 1'b0;
            quad_mode     <= 1'b0;
        end else begin
            status_word <= {paused_reg, nv_reg[BIT_INVERT], RESERVED_READ,
                nv_reg[BIT_QUAD:BIT_SIZE_LO], wel_reg, busy_reg};
            nv_store      <= state_reg == ST_WORK && reg_write_reg &&
                             op_done_int;
            nv_store_data <= pend_reg;
            op_start      <= state_reg == ST_IDLE && do_array && !do_wrstat;
            quad_mode     <= nv_reg[BIT_QUAD];
        end
    end

    // Checks
    a_busy_sets: assert property (@(posedge clock) disable iff (!rst_sys_n)
        (state_reg == ST_IDLE && do_wrstat) |=> busy_reg)
        else $error("busy not raised for status write");
    a_busy_ignore: assert property (@(posedge clock) disable iff (!rst_sys_n)
        (busy_reg && req_go_reg && req_reg.cmd == CMD_WREN) |=> !$rose(wel_reg))
        else $error("instruction taken while busy");
    a_busy_clear: assert property (@(posedge clock) disable iff (!rst_sys_n)
        (state_reg == ST_WORK && op_done_int && !accept) |=> !busy_reg)
        else $error("busy stuck after completion");
    a_wel_set: assert property (@(posedge clock) disable iff (!rst_sys_n)
        (accept && req_reg.cmd == CMD_WREN) |=> wel_reg)
        else $error("latch not set");
    a_wel_clear: assert property (@(posedge clock) disable iff (!rst_sys_n)
        (accept && req_reg.cmd == CMD_WRDIS) |=> !wel_reg)
        else $error("latch not cleared");
    a_lock_pin: assert property (@(posedge clock) disable iff (!rst_sys_n)
        (lock_pair == 2'b01 && !pin_s2_reg) |-> !do_wrstat)
        else $error("write passed with pin low");
    a_lock_hard: assert property (@(posedge clock) disable iff (!rst_sys_n)
        lock_pair[1] |-> !do_wrstat)
        else $error("write passed while locked");
    a_protect_ign: assert property (@(posedge clock) disable iff (!rst_sys_n)
        (req_go_reg && req_reg.hits_protected) |-> !do_array)
        else $error("protected program accepted");
    a_reserved_rd: assert property (@(posedge clock) disable iff (!rst_sys_n)
        status_word[13:10] == RESERVED_READ)
        else $error("reserved bits not fixed");

endmodule : fsr_status_regs

// ---- inc/fsr_pkg.sv ----
// Package for the flash status and protection register bank.
// Assumes one system clock plus an SPI-side clock for the host link.
package fsr_pkg;

    // Bit positions inside the 16-bit status word
    localparam int unsigned BIT_BUSY    = 0;
    localparam int unsigned BIT_WEL     = 1;
    localparam int unsigned BIT_SIZE_LO = 2;
    localparam int unsigned BIT_SIZE_HI = 4;
    localparam int unsigned BIT_LOW_END = 5;
    localparam int unsigned BIT_SMALL   = 6;
    localparam int unsigned BIT_LOCK_A  = 7;
    localparam int unsigned BIT_LOCK_B  = 8;
    localparam int unsigned BIT_QUAD    = 9;
    localparam int unsigned BIT_INVERT  = 14;
    localparam int unsigned BIT_PAUSED  = 15;

    // Factory defaults of the non-volatile bits and the reserved field value
    localparam logic [15:0] NV_FACTORY    = 16'h0000;
    localparam logic [3:0]  RESERVED_READ = 4'h0;
    // Mask of bits a status write may change
    localparam logic [15:0] WRITE_MASK    = 16'h43fc;

    // Length of an internal register write, in nanoseconds and cycles
    localparam int unsigned WRITE_TIME_NS = 1000;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned WRITE_CYCLES  =
        (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [15:0] WRITE_COUNT   = 16'(WRITE_CYCLES);

    // Decoded instruction kinds presented by the shift interface
    typedef enum logic [2:0] {
        CMD_NONE     = 3'b000,
        CMD_WREN     = 3'b001,
        CMD_WRDIS    = 3'b010,
        CMD_WRSTAT   = 3'b011,
        CMD_PROG     = 3'b100,
        CMD_ERASE    = 3'b101,
        CMD_SUSPEND  = 3'b110,
        CMD_RESUME   = 3'b111
    } fsr_cmd_t;

    // One instruction as it crosses from the link to the core
    typedef struct packed {
        fsr_cmd_t    cmd;      // Instruction kind
        logic [15:0] data;     // New status value for a status write
        logic        hits_protected; // Target touches a protected area
    } fsr_req_t;

    // Internal state machine of the array/register engine
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_WORK   = 2'b01,
        ST_PAUSED = 2'b10
    } fsr_state_t;

endpackage : fsr_pkg

// ---- test/fsr_host_model.sv ----
// Host model: sends decoded instructions over a gated link clock.
// Assumes the bench calls issue() and tick() from one process.
`timescale 1ns/1ns
module fsr_host_model (
    output logic              link_clock,    // Gated serial clock
    output fsr_pkg::fsr_req_t link_req,      // Instruction to device
    output logic              link_req_valid // High for one link edge
);
    import fsr_pkg::*;
    // Link idles with its clock stopped low
    initial begin
        link_clock     = 1'b0;
        link_req       = '0;
        link_req_valid = 1'b0;
    end
    // Clock runs only inside a frame, as a real host clock would
    task automatic tick(input int n);
        repeat (n) begin
            #80 link_clock = 1'b1;
            #80 link_clock = 1'b0;
        end
    endtask : tick
    // One instruction, qualified by exactly one rising link edge
    task automatic issue(input fsr_req_t r);
        #3;
        link_req       = r;
        link_req_valid = 1'b1;
        tick(1);
        link_req_valid = 1'b0;
        // Released lines carry the inverse, never a stale copy
        link_req       = ~r;
        tick(2);
    endtask : issue
endmodule : fsr_host_model

// ---- test/fsr_status_regs_test.sv ----
// Bench for the status bank: host traffic against a reference model.
// Assumes the host model owns the link clock; storage is modelled here.
`timescale 1ns/1ns
module fsr_status_regs_test;
    import fsr_pkg::*;
    logic        clock, rst_n, protect_pin, op_done;  // Drives
    logic [15:0] nv_image, status_word, nv_store_data;
    logic        nv_store, op_start, quad_mode;       // Observed pulses and quad level
    logic        link_clock, link_req_valid;          // Link side
    fsr_req_t    link_req;                            // Link payload
    int          mismatches, checks, starts, stores;  // Counters
    logic [15:0] exp;                                 // Expected word
    logic [31:0] seed = 32'd96058;                    // Xorshift state

    fsr_status_regs dut (.clock(clock), .rst_n(rst_n),
        .link_clock(link_clock), .link_rst_n(rst_n), .link_req(link_req),
        .link_req_valid(link_req_valid), .protect_pin(protect_pin),
        .op_done(op_done), .nv_image(nv_image), .status_word(status_word),
        .nv_store(nv_store), .nv_store_data(nv_store_data),
        .op_start(op_start), .quad_mode(quad_mode));
    fsr_host_model host (.link_clock(link_clock), .link_req(link_req),
        .link_req_valid(link_req_valid));

    // System clock, 10 ns
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // Storage keeps whatever the bank stores, so images survive resets
    always @(posedge clock) begin
        if (nv_store === 1'b1) begin
            stores++;
            nv_image <= nv_store_data;
        end
        if (op_start === 1'b1)
            starts++;
    end
    function automatic logic [15:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[15:0];
    endfunction : rnd
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        checks++;
        if (seen !== want) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check
    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    // Power cycle; volatile bits come back clear
    task automatic power_up();
        @(negedge clock) rst_n = 1'b0;
        repeat (8) @(negedge clock);
        rst_n = 1'b1;
        host.tick(2);
        exp = nv_image & WRITE_MASK;
        if (exp[8:7] == 2'b10)
            exp[8:7] = 2'b00;
        check(status_word, exp);
    endtask : power_up
    task automatic send(input fsr_cmd_t c, input logic [15:0] d,
                        input logic h);
        host.issue({c, d, h});
        repeat (2) @(negedge clock);
    endtask : send
    // Latch, then status write; ok says whether it must be taken
    task automatic wrstat(input logic [15:0] d, input logic ok);
        int n;
        int s0;
        s0 = stores;
        send(CMD_WREN, 16'h0000, 1'b0);
        check(16'(status_word[1]), 16'h0001);
        send(CMD_WRSTAT, d, 1'b0);
        if (ok) begin
            check(16'(status_word[0]), 16'h0001);
            // A latch set while busy must be lost
            send(CMD_WREN, 16'h0000, 1'b0);
            n = 0;
            while (status_word[0] !== 1'b0 && n < 300) begin
                @(negedge clock);
                n++;
            end
            // A write that never ends counts as a mismatch here
            check(16'(status_word[0]), 16'h0000);
            repeat (3) @(negedge clock);
            exp = (exp & ~WRITE_MASK) | (d & WRITE_MASK);
            check(16'(stores - s0), 16'h0001);
        end else begin
            send(CMD_WRDIS, 16'h0000, 1'b0);
            check(16'(stores - s0), 16'h0000);
        end
        check(status_word, exp);
        check(16'(quad_mode), 16'(exp[9]));
    endtask : wrstat
    // Array operation; an unprotected one is paused and resumed in the middle
    task automatic array_op(input fsr_cmd_t c, input logic h);
        int s0;
        s0 = starts;
        send(CMD_WREN, 16'h0000, 1'b0);
        send(c, 16'h0000, h);
        check(16'(starts - s0), 16'(!h));
        if (!h) begin
            check(16'(status_word[1:0]), 16'h0001);
            send(CMD_SUSPEND, 16'h0000, 1'b0);
            check(16'(status_word[15]), 16'h0001);
            send(CMD_RESUME, 16'h0000, 1'b0);
            check(16'(status_word[15]), 16'h0000);
            @(negedge clock) op_done = 1'b1;
            @(negedge clock) op_done = 1'b0;
            repeat (6) @(negedge clock);
        end else
            send(CMD_WRDIS, 16'h0000, 1'b0);
        check(status_word, exp);
    endtask : array_op

    // Watchdog: far beyond the roughly 35 us the sequence needs
    initial begin
        #500000;
        mismatches++;
        end_of_test();
    end
    // Main sequence
    initial begin
        rst_n       = 1'b0;
        op_done     = 1'b0;
        // Pin driven, never tied, so quad writes are harmless
        protect_pin = 1'b1;
        nv_image    = NV_FACTORY;
        power_up();
        nv_image = (rnd() & 16'hfe7f) | 16'h0100;
        power_up();
        array_op(CMD_PROG, 1'b0);
        array_op(CMD_ERASE, 1'b1);
        array_op(CMD_ERASE, 1'b0);
        // Free writes whatever the pin does
        repeat (8) begin
            protect_pin = rnd() & 16'h0001;
            wrstat(rnd() & 16'hfe7f, 1'b1);
        end
        protect_pin = 1'b1;
        wrstat((rnd() & 16'hfe7f) | 16'h0080, 1'b1);
        protect_pin = 1'b0;
        wrstat(rnd(), 1'b0);
        protect_pin = 1'b1;
        wrstat((rnd() & 16'hfe7f) | 16'h0080, 1'b1);
        wrstat((rnd() & 16'hfe7f) | 16'h0100, 1'b1);
        wrstat(rnd(), 1'b0);
        power_up();
        wrstat(rnd() | 16'h0180, 1'b1);
        wrstat(rnd(), 1'b0);
        power_up();
        wrstat(rnd() & 16'hfe7f, 1'b0);
        end_of_test();
    end
endmodule : fsr_status_regs_test
